// ==== tmr_regs.sv ====
// lower register map (00h..20h) of a multi-channel temperature monitor
// assumes the smbus engine presents one byte access per pulse on reg_rd
// or reg_wr, synchronous to core_clk; measurement logic feeds the
// temperature, event and fault inputs
//
// Overview of operation
// - registers reached only through the smbus register access port
// - unlisted addresses ignore writes and read as zero
// - general configuration shared at 03h and 09h, reset 00h
// - conversion rate shared at 04h and 0Ah, reset 06h
// - internal high limit shared at 05h and 0Bh, reset 55h
// - internal low limit shared at 06h and 0Ch, reset 00h
// - remote 1 high limit integer shared at 07h and 0Dh, reset 55h
// - remote 1 low limit integer shared at 08h and 0Eh, reset 00h
// - main status at 02h, reset 00h, clears set bits on read
// - per-channel diode fault flags at 1Bh, reset 00h, clear on read
// - temperatures as read-only integer and fraction bytes, reset zero
// - writable critical limits 19h, 1Ah, 20h resetting to 55h
// - 1Ch returns the threshold pin voltage, read-only
// - 1Eh returns selected hardware shutdown limit, read-only
// - 1Dh selects channels driving the shutdown output, reset 00h
// - 1Fh holds per-channel interrupt masks, reset F0h
// - remote 1 fraction limits at 13h and 14h, reset 00h
// - remote 2 limits at 15h..18h, resets 55h,00h,00h,00h
// - diode fault forces integer byte to 80h and sets status fault
`timescale 1ns/10ps

module tmr_regs
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// register access from the smbus engine
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	// measurement results
	input  wire logic        meas_valid,
	input  wire logic [7:0]  int_temp_meas,
	input  wire logic [7:0]  r1_temp_meas,
	input  wire logic [7:0]  r1_frac_meas,
	input  wire logic [7:0]  pin_volt_meas,
	input  wire logic [7:0]  hw_shdn_limit,
	// events
	input  wire logic [7:0]  status_set,
	input  wire logic [7:0]  diode_fault,
	input  wire logic        int_diode_fault,
	// configuration seen by the core
	output logic      [7:0]  general_config,
	output logic      [7:0]  sample_rate_select,
	output logic      [7:0]  shutdown_channel_link,
	output logic      [7:0]  channel_irq_mask
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0] cfg_q, rate_q, int_hi_q, int_lo_q;
	logic [7:0] r1_hi_q, r1_lo_q, r1_hi_f_q, r1_lo_f_q;
	logic [7:0] r2_hi_q, r2_lo_q, r2_hi_f_q, r2_lo_f_q;
	logic [7:0] r1_crit_q, r2_crit_q, int_crit_q;
	logic [7:0] shdn_q, mask_q;
	logic [7:0] int_temp_q, r1_temp_q, r1_frac_q, volt_q, hw_q;
	logic [7:0] status_q, fault_q;
	logic [7:0] rdata_q;
	logic       rvalid_q;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction : hit

	function automatic logic hit2(input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] c);
		hit2 = (a == b) || (a == c);
	endfunction : hit2

	wire wr_cfg     = reg_wr && hit2(reg_addr, tmr_pkg::ADDR_CFG,
		tmr_pkg::ADDR_CFG_ALIAS);
	wire wr_rate    = reg_wr && hit2(reg_addr, tmr_pkg::ADDR_RATE,
		tmr_pkg::ADDR_RATE_ALIAS);
	wire wr_int_hi  = reg_wr && hit2(reg_addr, tmr_pkg::ADDR_INT_HI,
		tmr_pkg::ADDR_INT_HI_ALIAS);
	wire wr_int_lo  = reg_wr && hit2(reg_addr, tmr_pkg::ADDR_INT_LO,
		tmr_pkg::ADDR_INT_LO_ALIAS);
	wire wr_r1_hi   = reg_wr && hit2(reg_addr, tmr_pkg::ADDR_R1_HI_INT,
		tmr_pkg::ADDR_R1_HI_ALIAS);
	wire wr_r1_lo   = reg_wr && hit2(reg_addr, tmr_pkg::ADDR_R1_LO_INT,
		tmr_pkg::ADDR_R1_LO_ALIAS);
	wire wr_r1_hi_f = reg_wr && hit(reg_addr, tmr_pkg::ADDR_R1_HI_FRAC);
	wire wr_r1_lo_f = reg_wr && hit(reg_addr, tmr_pkg::ADDR_R1_LO_FRAC);
	wire wr_r2_hi   = reg_wr && hit(reg_addr, tmr_pkg::ADDR_R2_HI_INT);
	wire wr_r2_lo   = reg_wr && hit(reg_addr, tmr_pkg::ADDR_R2_LO_INT);
	wire wr_r2_hi_f = reg_wr && hit(reg_addr, tmr_pkg::ADDR_R2_HI_FRAC);
	wire wr_r2_lo_f = reg_wr && hit(reg_addr, tmr_pkg::ADDR_R2_LO_FRAC);
	wire wr_r1_crit = reg_wr && hit(reg_addr, tmr_pkg::ADDR_R1_CRIT);
	wire wr_r2_crit = reg_wr && hit(reg_addr, tmr_pkg::ADDR_R2_CRIT);
	wire wr_in_crit = reg_wr && hit(reg_addr, tmr_pkg::ADDR_INT_CRIT);
	wire wr_shdn    = reg_wr && hit(reg_addr, tmr_pkg::ADDR_SHDN_LINK);
	wire wr_mask    = reg_wr && hit(reg_addr, tmr_pkg::ADDR_IRQ_MASK);

	wire rd_status  = reg_rd && hit(reg_addr, tmr_pkg::ADDR_STATUS);
	wire rd_fault   = reg_rd && hit(reg_addr, tmr_pkg::ADDR_FAULT);

	// a new event in the clearing cycle survives the read
	wire [7:0] status_ev = status_set |
		(int_diode_fault || (|diode_fault) ?
		8'(1 << tmr_pkg::STATUS_FAULT_BIT) : 8'h00);
	wire [7:0] status_d = (rd_status ? 8'h00 : status_q) | status_ev;
	wire [7:0] fault_d  = (rd_fault ? 8'h00 : fault_q) | diode_fault;

	// faulted channels report the fault code in the integer byte
	wire [7:0] int_temp_d = int_diode_fault ? tmr_pkg::FAULT_TEMP_CODE
		: int_temp_meas;
	wire [7:0] r1_temp_d  = diode_fault[0] ? tmr_pkg::FAULT_TEMP_CODE
		: r1_temp_meas;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	logic [7:0] rmux;
	always_comb
	begin
		unique case (reg_addr)
			tmr_pkg::ADDR_INT_TEMP:     rmux = int_temp_q;
			tmr_pkg::ADDR_R1_TEMP:      rmux = r1_temp_q;
			tmr_pkg::ADDR_R1_FRAC:      rmux = r1_frac_q;
			tmr_pkg::ADDR_STATUS:       rmux = status_q;
			tmr_pkg::ADDR_CFG,
			tmr_pkg::ADDR_CFG_ALIAS:    rmux = cfg_q;
			tmr_pkg::ADDR_RATE,
			tmr_pkg::ADDR_RATE_ALIAS:   rmux = rate_q;
			tmr_pkg::ADDR_INT_HI,
			tmr_pkg::ADDR_INT_HI_ALIAS: rmux = int_hi_q;
			tmr_pkg::ADDR_INT_LO,
			tmr_pkg::ADDR_INT_LO_ALIAS: rmux = int_lo_q;
			tmr_pkg::ADDR_R1_HI_INT,
			tmr_pkg::ADDR_R1_HI_ALIAS:  rmux = r1_hi_q;
			tmr_pkg::ADDR_R1_LO_INT,
			tmr_pkg::ADDR_R1_LO_ALIAS:  rmux = r1_lo_q;
			tmr_pkg::ADDR_R1_HI_FRAC:   rmux = r1_hi_f_q;
			tmr_pkg::ADDR_R1_LO_FRAC:   rmux = r1_lo_f_q;
			tmr_pkg::ADDR_R2_HI_INT:    rmux = r2_hi_q;
			tmr_pkg::ADDR_R2_LO_INT:    rmux = r2_lo_q;
			tmr_pkg::ADDR_R2_HI_FRAC:   rmux = r2_hi_f_q;
			tmr_pkg::ADDR_R2_LO_FRAC:   rmux = r2_lo_f_q;
			tmr_pkg::ADDR_R1_CRIT:      rmux = r1_crit_q;
			tmr_pkg::ADDR_R2_CRIT:      rmux = r2_crit_q;
			tmr_pkg::ADDR_INT_CRIT:     rmux = int_crit_q;
			tmr_pkg::ADDR_FAULT:        rmux = fault_q;
			tmr_pkg::ADDR_PIN_VOLT:     rmux = volt_q;
			tmr_pkg::ADDR_SHDN_LINK:    rmux = shdn_q;
			tmr_pkg::ADDR_HW_SHDN:      rmux = hw_q;
			tmr_pkg::ADDR_IRQ_MASK:     rmux = mask_q;
			default:                    rmux = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// writable registers
	// ----------------------------------------------------------------
	// every write goes through the access port only; others ignored
	// one short process per register keeps its enable beside its reset
	always_ff @(posedge core_clk)
	begin
		if (srst)
			cfg_q <= tmr_pkg::RST_ZERO;
		else if (wr_cfg)
			cfg_q <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			rate_q <= tmr_pkg::RST_RATE;
		else if (wr_rate)
			rate_q <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			int_hi_q <= tmr_pkg::RST_LIMIT_HI;
		else if (wr_int_hi)
			int_hi_q <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			int_lo_q <= tmr_pkg::RST_ZERO;
		else if (wr_int_lo)
			int_lo_q <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			r1_hi_q <= tmr_pkg::RST_LIMIT_HI;
		else if (wr_r1_hi)
			r1_hi_q <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			r1_lo_q <= tmr_pkg::RST_ZERO;
		else if (wr_r1_lo)
			r1_lo_q <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			r1_hi_f_q <= tmr_pkg::RST_ZERO;
		else if (wr_r1_hi_f)
			r1_hi_f_q <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			r1_lo_f_q <= tmr_pkg::RST_ZERO;
		else if (wr_r1_lo_f)
			r1_lo_f_q <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			r2_hi_q <= tmr_pkg::RST_LIMIT_HI;
		else if (wr_r2_hi)
			r2_hi_q <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			r2_lo_q <= tmr_pkg::RST_ZERO;
		else if (wr_r2_lo)
			r2_lo_q <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			r2_hi_f_q <= tmr_pkg::RST_ZERO;
		else if (wr_r2_hi_f)
			r2_hi_f_q <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			r2_lo_f_q <= tmr_pkg::RST_ZERO;
		else if (wr_r2_lo_f)
			r2_lo_f_q <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			r1_crit_q <= tmr_pkg::RST_LIMIT_HI;
		else if (wr_r1_crit)
			r1_crit_q <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			r2_crit_q <= tmr_pkg::RST_LIMIT_HI;
		else if (wr_r2_crit)
			r2_crit_q <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			int_crit_q <= tmr_pkg::RST_LIMIT_HI;
		else if (wr_in_crit)
			int_crit_q <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			shdn_q <= tmr_pkg::RST_ZERO;
		else if (wr_shdn)
			shdn_q <= reg_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			mask_q <= tmr_pkg::RST_IRQ_MASK;
		else if (wr_mask)
			mask_q <= reg_wdata;
	end

	// ----------------------------------------------------------------
	// measured values and status
	// ----------------------------------------------------------------
	// hardware limit has no defined reset; it simply tracks its input
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			int_temp_q <= tmr_pkg::RST_ZERO;
			r1_temp_q  <= tmr_pkg::RST_ZERO;
			r1_frac_q  <= tmr_pkg::RST_ZERO;
			volt_q     <= tmr_pkg::RST_ZERO;
			status_q   <= tmr_pkg::RST_ZERO;
			fault_q    <= tmr_pkg::RST_ZERO;
		end
		else
		begin
			if (meas_valid)
			begin
				int_temp_q <= int_temp_d;
				r1_temp_q  <= r1_temp_d;
				r1_frac_q  <= r1_frac_meas;
				volt_q     <= pin_volt_meas;
			end
			status_q <= status_d;
			fault_q  <= fault_d;
		end
	end

	always_ff @(posedge core_clk)
	begin
		hw_q <= hw_shdn_limit;
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			rdata_q  <= tmr_pkg::RST_ZERO;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= reg_rd;
			rdata_q  <= reg_rd ? rmux : 8'h00;
		end
	end

	assign reg_rdata             = rdata_q;
	assign reg_rvalid            = rvalid_q;
	assign general_config        = cfg_q;
	assign sample_rate_select    = rate_q;
	assign shutdown_channel_link = shdn_q;
	assign channel_irq_mask      = mask_q;

endmodule : tmr_regs

// ==== tmr_pkg.sv ====
// package for the thermal monitor lower register map
// assumes a byte-wide register access port driven by an smbus engine
package tmr_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_INT_TEMP      = 8'h00;
	localparam logic [7:0] ADDR_R1_TEMP       = 8'h01;
	localparam logic [7:0] ADDR_STATUS        = 8'h02;
	localparam logic [7:0] ADDR_CFG           = 8'h03;
	localparam logic [7:0] ADDR_RATE          = 8'h04;
	localparam logic [7:0] ADDR_INT_HI        = 8'h05;
	localparam logic [7:0] ADDR_INT_LO        = 8'h06;
	localparam logic [7:0] ADDR_R1_HI_INT     = 8'h07;
	localparam logic [7:0] ADDR_R1_LO_INT     = 8'h08;
	localparam logic [7:0] ADDR_CFG_ALIAS     = 8'h09;
	localparam logic [7:0] ADDR_RATE_ALIAS    = 8'h0A;
	localparam logic [7:0] ADDR_INT_HI_ALIAS  = 8'h0B;
	localparam logic [7:0] ADDR_INT_LO_ALIAS  = 8'h0C;
	localparam logic [7:0] ADDR_R1_HI_ALIAS   = 8'h0D;
	localparam logic [7:0] ADDR_R1_LO_ALIAS   = 8'h0E;
	localparam logic [7:0] ADDR_R1_FRAC       = 8'h10;
	localparam logic [7:0] ADDR_R1_HI_FRAC    = 8'h13;
	localparam logic [7:0] ADDR_R1_LO_FRAC    = 8'h14;
	localparam logic [7:0] ADDR_R2_HI_INT     = 8'h15;
	localparam logic [7:0] ADDR_R2_LO_INT     = 8'h16;
	localparam logic [7:0] ADDR_R2_HI_FRAC    = 8'h17;
	localparam logic [7:0] ADDR_R2_LO_FRAC    = 8'h18;
	localparam logic [7:0] ADDR_R1_CRIT       = 8'h19;
	localparam logic [7:0] ADDR_R2_CRIT       = 8'h1A;
	localparam logic [7:0] ADDR_FAULT         = 8'h1B;
	localparam logic [7:0] ADDR_PIN_VOLT      = 8'h1C;
	localparam logic [7:0] ADDR_SHDN_LINK     = 8'h1D;
	localparam logic [7:0] ADDR_HW_SHDN       = 8'h1E;
	localparam logic [7:0] ADDR_IRQ_MASK      = 8'h1F;
	localparam logic [7:0] ADDR_INT_CRIT      = 8'h20;

	// ----------------------------------------------------------------
	// reset values and codes
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_ZERO           = 8'h00;
	localparam logic [7:0] RST_RATE           = 8'h06;
	localparam logic [7:0] RST_LIMIT_HI       = 8'h55;
	localparam logic [7:0] RST_IRQ_MASK       = 8'hF0;
	localparam logic [7:0] FAULT_TEMP_CODE    = 8'h80;

	// ----------------------------------------------------------------
	// status field positions
	// ----------------------------------------------------------------
	localparam int STATUS_FAULT_BIT = 2;

endpackage : tmr_pkg

// ==== tmr_regs_assertions.sv ====
// checker for the port behaviour of the lower register map
// assumes it is bound into tmr_regs and sees only that module's ports
`timescale 1ns/10ps

module tmr_regs_assertions
(
	// clock and reset
	input wire logic       core_clk,
	input wire logic       srst,
	// register access
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	// configuration copies
	input wire logic [7:0] general_config,
	input wire logic [7:0] sample_rate_select,
	input wire logic [7:0] shutdown_channel_link,
	input wire logic [7:0] channel_irq_mask
);
	// ----------------------------------------------------------------
	// access timing and register updates
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	a_read_answered: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered one cycle later");
	a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read valid without a read");
	a_idle_rdata: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
		else $error("read data not zero while idle");
	a_unlisted_zero: assert property (reg_rd && (reg_addr > 8'h20 ||
		reg_addr inside {8'h0F, 8'h11, 8'h12}) |=> reg_rdata == 8'h00)
		else $error("unlisted address read not zero");
	a_cfg_write: assert property (reg_wr && reg_addr inside {8'h03,
		8'h09} |=> general_config == $past(reg_wdata))
		else $error("configuration write not taken");
	a_cfg_hold: assert property (!(reg_wr && reg_addr inside {8'h03,
		8'h09}) |=> $stable(general_config))
		else $error("configuration changed without a write");
	a_rate_write: assert property (reg_wr && reg_addr inside {8'h04,
		8'h0A} |=> sample_rate_select == $past(reg_wdata))
		else $error("rate write not taken");
	a_link_write: assert property (reg_wr && reg_addr == 8'h1D
		|=> shutdown_channel_link == $past(reg_wdata))
		else $error("shutdown link write not taken");
	a_mask_write: assert property (reg_wr && reg_addr == 8'h1F
		|=> channel_irq_mask == $past(reg_wdata))
		else $error("mask write not taken");
endmodule : tmr_regs_assertions

bind tmr_regs tmr_regs_assertions u_chk (.core_clk(core_clk), .srst(srst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.general_config(general_config), .sample_rate_select(sample_rate_select),
	.shutdown_channel_link(shutdown_channel_link),
	.channel_irq_mask(channel_irq_mask));

// ==== tmr_host_model.sv ====
// host side model: the smbus engine issuing single byte accesses
// assumes one access at a time, with at least one idle cycle between strobes
`timescale 1ns/10ps

module tmr_host_model
(
	// clock
	input  wire logic       core_clk,
	// register access
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		// stale data would hide a write taken on the wrong cycle
		reg_wdata <= ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		d = reg_rvalid ? reg_rdata : ~reg_rdata;
	endtask : rd
endmodule : tmr_host_model

// ==== test_thermal_monitor_register_map_low.sv ====
// self-checking bench for the lower register map
// assumes tmr_regs, tmr_host_model and the bound checker are compiled
`timescale 1ns/10ps

module test_thermal_monitor_register_map_low;
	localparam logic [15:0] RST_TAB [0:31] = '{16'h0000, 16'h0100, 16'h0200,
		16'h0300, 16'h0406, 16'h0555, 16'h0600, 16'h0755, 16'h0800, 16'h0900,
		16'h0A06, 16'h0B55, 16'h0C00, 16'h0D55, 16'h0E00, 16'h0F00, 16'h1000,
		16'h1100, 16'h1200, 16'h1300, 16'h1400, 16'h1555, 16'h1600, 16'h1700,
		16'h1800, 16'h1955, 16'h1A55, 16'h1B00, 16'h1C00, 16'h1D00, 16'h1FF0,
		16'h2055};
	localparam logic [7:0] RO_TAB [0:9] = '{8'h00, 8'h01, 8'h10, 8'h1C,
		8'h0F, 8'h11, 8'h12, 8'h21, 8'h02, 8'h1B};
	logic       core_clk, srst, meas_valid, int_diode_fault;
	logic       reg_wr, reg_rd, reg_rvalid;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, i;
	logic [7:0] int_temp_meas, r1_temp_meas, r1_frac_meas, pin_volt_meas;
	logic [7:0] hw_shdn_limit, status_set, diode_fault;
	logic [7:0] general_config, sample_rate_select;
	logic [7:0] shutdown_channel_link, channel_irq_mask;
	int         err_count, checked, cycles;

	tmr_host_model u_host (.core_clk(core_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	tmr_regs u_dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.meas_valid(meas_valid), .int_temp_meas(int_temp_meas),
		.r1_temp_meas(r1_temp_meas), .r1_frac_meas(r1_frac_meas),
		.pin_volt_meas(pin_volt_meas), .hw_shdn_limit(hw_shdn_limit),
		.status_set(status_set), .diode_fault(diode_fault),
		.int_diode_fault(int_diode_fault), .general_config(general_config),
		.sample_rate_select(sample_rate_select),
		.shutdown_channel_link(shutdown_channel_link),
		.channel_irq_mask(channel_irq_mask));

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check8

	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_host.rd(a, d);
		check8(d, exp);
	endtask : rc

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// a hung handshake ends the run as a mismatch
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_count++;
			print_verdict();
		end
	end

	initial
	begin
		{srst, meas_valid, int_diode_fault} = 3'b100;
		{int_temp_meas, r1_temp_meas, r1_frac_meas} = 24'h000000;
		{pin_volt_meas, hw_shdn_limit} = 16'h0064;
		{status_set, diode_fault} = 16'h0000;
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		for (int k = 0; k < 15; k++)
			rc(RST_TAB[k][15:8], RST_TAB[k][7:0]);
		for (int k = 15; k < 25; k++)
			rc(RST_TAB[k][15:8], RST_TAB[k][7:0]);
		for (int k = 25; k < 32; k++)
			rc(RST_TAB[k][15:8], RST_TAB[k][7:0]);
		check8(sample_rate_select, 8'h06);
		check8(channel_irq_mask, 8'hF0);
		$display("test reset values done");
		for (i = 8'h00; i < 8'h06; i++)
		begin
			u_host.wr(8'h03 + i, 8'hA0 + i);
			rc(8'h09 + i, 8'hA0 + i);
			u_host.wr(8'h09 + i, 8'h5A - i);
			rc(8'h03 + i, 8'h5A - i);
		end
		check8(general_config, 8'h5A);
		check8(sample_rate_select, 8'h59);
		$display("test mirrored registers done");
		for (i = 8'h13; i < 8'h1B; i++)
		begin
			u_host.wr(i, ~i);
			rc(i, ~i);
		end
		u_host.wr(8'h1D, 8'h3C);
		rc(8'h1D, 8'h3C);
		check8(shutdown_channel_link, 8'h3C);
		u_host.wr(8'h1F, 8'h0F);
		rc(8'h1F, 8'h0F);
		check8(channel_irq_mask, 8'h0F);
		u_host.wr(8'h20, 8'h77);
		rc(8'h20, 8'h77);
		$display("test writable registers done");
		for (int k = 0; k < 10; k++)
		begin
			u_host.wr(RO_TAB[k], 8'hFF);
			rc(RO_TAB[k], 8'h00);
		end
		$display("test read-only and unlisted done");
		@(posedge core_clk);
		{int_temp_meas, r1_temp_meas, r1_frac_meas} <= 24'h2A3BE0;
		{pin_volt_meas, hw_shdn_limit, meas_valid} <= 17'h122CD;
		@(posedge core_clk);
		meas_valid <= 1'b0;
		rc(8'h00, 8'h2A);
		rc(8'h01, 8'h3B);
		rc(8'h10, 8'hE0);
		rc(8'h1C, 8'h91);
		rc(8'h1E, 8'h66);
		@(posedge core_clk);
		{int_diode_fault, diode_fault, meas_valid} <= 10'h203;
		@(posedge core_clk);
		{int_diode_fault, diode_fault, meas_valid} <= 10'h000;
		rc(8'h00, 8'h80);
		rc(8'h01, 8'h80);
		rc(8'h02, 8'h04);
		rc(8'h02, 8'h00);
		rc(8'h1B, 8'h01);
		rc(8'h1B, 8'h00);
		@(posedge core_clk);
		status_set <= 8'hA1;
		@(posedge core_clk);
		status_set <= 8'h00;
		rc(8'h02, 8'hA1);
		rc(8'h02, 8'h00);
		$display("test measurement and events done");
		// a reset in mid-run must bring written registers back
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		rc(8'h09, 8'h00);
		rc(8'h0A, 8'h06);
		rc(8'h1D, 8'h00);
		check8(general_config, 8'h00);
		check8(channel_irq_mask, 8'hF0);
		$display("test reset in mid-run done");
		print_verdict();
	end
endmodule : test_thermal_monitor_register_map_low
